// file: logic/phy_event_params.svh
// Purpose: Offsets, field positions, reset values of the event status block
// Assumes: APB byte addresses are four times the register index
// Notes:   Included by the top module, the checker and the bench
`ifndef PHY_EVENT_PARAMS_SVH
`define PHY_EVENT_PARAMS_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define IDX_CONTROL           16'h0011
`define IDX_STATUS_ONE        16'h0012
`define IDX_STATUS_TWO        16'h0013
`define IDX_FALSE_CARRIER     16'h0014
`define IDX_RX_ERROR          16'h0015
`define ADDR_CONTROL          8'h44
`define ADDR_STATUS_ONE       8'h48
`define ADDR_STATUS_TWO       8'h4C
`define ADDR_FALSE_CARRIER    8'h50
`define ADDR_RX_ERROR         8'h54

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_INT_EN_BIT       1
`define CTRL_INT_OE_BIT       0
`define ONE_FC_HALF_BIT       9
`define ONE_RE_HALF_BIT       8
`define ONE_FC_EN_BIT         1
`define ONE_RE_EN_BIT         0
`define TWO_PEND_LSB          8
`define TWO_EN_LSB            0
`define TWO_MASK              16'h7F7F
`define TWO_COR_MASK          7'h7E
`define ONE_COR_MASK          7'h03

// ****************************************************************
// Reset values and counter limits
// ****************************************************************
`define RESET_WORD            16'h0000
`define FC_MAX                8'hFF
`define FC_HALF               8'h7F
`define RE_MAX                16'hFFFF
`define RE_HALF               16'h7FFF

`endif

// file: logic/phy_event_pkg.sv
// Purpose: Types of the event status block
// Assumes: Nothing
// Notes:   Event order matches status bits 14 down to 8
package phy_event_pkg;
    typedef enum logic [2:0] {
        APB_IDLE   = 3'b001,
        APB_SETUP  = 3'b010,
        APB_ACCESS = 3'b100
    } apb_phase_t;
    typedef logic [6:0] event_vec_t;
endpackage : phy_event_pkg

// file: logic/phy_event_status_and_error_counters.sv
// Purpose: Event status, enables and error counters of a PHY, over APB
// Assumes: Event inputs are one-cycle pulses synchronous to pclk
// Notes:   Status and counters clear on APB read, except the jabber bit; events win over clear
`timescale 1ns/1ps
`include "phy_event_params.svh"

module phy_event_status_and_error_counters
    import phy_event_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Event pulses
    input  wire logic                  autoneg_fault_event,
    input  wire logic                  page_received_event,
    input  wire logic                  loop_fifo_fault_event,
    input  wire logic                  crossover_change_event,
    input  wire logic                  sleep_mode_event,
    input  wire logic                  polarity_change_event,
    input  wire logic                  jabber_event,
    input  wire logic                  false_carrier_event,
    // Receive path state
    input  wire logic                  rx_dv,
    input  wire logic                  carrier_valid,
    input  wire logic                  invalid_symbol,
    input  wire logic                  mii_loopback,
    // Shared interrupt / power-down pin
    input  wire logic                  irq_powerdown_pin_in,
    output logic                       irq_powerdown_pin_out_n,
    output logic                       irq_powerdown_pin_oe,
    output logic                       powerdown_request
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    // Decoder compares the low byte against the register map
    if (ADDR_WIDTH < 8) begin : g_bad_addr_width
        $error("ADDR_WIDTH must be at least 8");
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    apb_phase_t  phase;
    event_vec_t  two_pending;
    event_vec_t  two_enable;
    logic [1:0]  one_pending;
    logic [1:0]  one_enable;
    logic        int_en;
    logic        int_oe;
    logic [7:0]  false_carrier_tally;
    logic [15:0] rx_error_tally;

    event_vec_t  raw_events;
    logic        wr_take;
    logic        rd_take;
    logic        hit_ctrl;
    logic        hit_one;
    logic        hit_two;
    logic        hit_fc;
    logic        hit_re;
    logic        hit_any;
    logic        fc_inc;
    logic        re_inc;
    logic        fc_half_event;
    logic        re_half_event;
    logic        irq_request;
    logic [15:0] next_read;

    // Named status and enable fields
    logic        autoneg_fault_pending;
    logic        page_received_pending;
    logic        loop_fifo_fault_pending;
    logic        crossover_change_pending;
    logic        sleep_mode_pending;
    logic        polarity_change_pending;
    logic        jabber_pending;
    logic        autoneg_fault_enable;
    logic        page_received_enable;
    logic        loop_fifo_fault_enable;
    logic        crossover_change_enable;
    logic        sleep_mode_enable;
    logic        polarity_change_enable;
    logic        jabber_enable;
    logic        false_carrier_half_pending;
    logic        rx_error_half_pending;
    logic        false_carrier_half_enable;
    logic        rx_error_half_enable;

    // Values reported by the read in progress
    event_vec_t  two_reported;
    logic [1:0]  one_reported;
    logic [7:0]  fc_reported;
    logic [15:0] re_reported;
    event_vec_t  one_after_read;
    logic [15:0] fc_after_read;
    logic [15:0] re_after_read;

    function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a,
                                     input logic [7:0] target);
        addr_is = (a[7:0] == target) && (a >> 8 == '0);
    endfunction : addr_is

    // Clear only what the read word showed; new events stay
    function automatic event_vec_t flags_after_read(input event_vec_t now,
                                                    input event_vec_t seen,
                                                    input event_vec_t mask,
                                                    input event_vec_t events);
        flags_after_read = (now & ~(seen & mask)) | events;
    endfunction : flags_after_read

    // Counts gained after the read word was taken survive the clear
    function automatic logic [15:0] count_after_read(input logic [15:0] now,
                                                     input logic [15:0] seen,
                                                     input logic        step);
        count_after_read = now - seen + {15'h0000, step};
    endfunction : count_after_read

    assign raw_events = {autoneg_fault_event, page_received_event, loop_fifo_fault_event,
                         crossover_change_event, sleep_mode_event,
                         polarity_change_event, jabber_event};
    assign hit_ctrl   = addr_is(paddr, `ADDR_CONTROL);
    assign hit_one    = addr_is(paddr, `ADDR_STATUS_ONE);
    assign hit_two    = addr_is(paddr, `ADDR_STATUS_TWO);
    assign hit_fc     = addr_is(paddr, `ADDR_FALSE_CARRIER);
    assign hit_re     = addr_is(paddr, `ADDR_RX_ERROR);
    assign hit_any    = hit_ctrl | hit_one | hit_two | hit_fc | hit_re;
    // Access completes in the second access cycle, when pready is high
    assign wr_take    = psel & penable & pready & pwrite & hit_any;
    assign rd_take    = psel & penable & pready & ~pwrite & hit_any;

    // ****************************************************************
    // Named fields
    // ****************************************************************
    assign autoneg_fault_pending      = two_pending[6];
    assign page_received_pending      = two_pending[5];
    assign loop_fifo_fault_pending    = two_pending[4];
    assign crossover_change_pending   = two_pending[3];
    assign sleep_mode_pending         = two_pending[2];
    assign polarity_change_pending    = two_pending[1];
    assign jabber_pending             = two_pending[0];
    assign autoneg_fault_enable       = two_enable[6];
    assign page_received_enable       = two_enable[5];
    assign loop_fifo_fault_enable     = two_enable[4];
    assign crossover_change_enable    = two_enable[3];
    assign sleep_mode_enable          = two_enable[2];
    assign polarity_change_enable     = two_enable[1];
    assign jabber_enable              = two_enable[0];
    assign false_carrier_half_pending = one_pending[1];
    assign rx_error_half_pending      = one_pending[0];
    assign false_carrier_half_enable  = one_enable[1];
    assign rx_error_half_enable       = one_enable[0];

    // ****************************************************************
    // Read word in flight
    // ****************************************************************
    // Word was taken one cycle before the clear lands
    assign two_reported   = prdata[`TWO_PEND_LSB +: 7];
    assign one_reported   = {prdata[`ONE_FC_HALF_BIT], prdata[`ONE_RE_HALF_BIT]};
    assign fc_reported    = prdata[7:0];
    assign re_reported    = prdata[15:0];
    assign one_after_read = flags_after_read({5'h00, one_pending},
                                             {5'h00, one_reported},
                                             `ONE_COR_MASK,
                                             {5'h00, fc_half_event, re_half_event});
    assign fc_after_read  = count_after_read({8'h00, false_carrier_tally},
                                             {8'h00, fc_reported},
                                             false_carrier_event);
    assign re_after_read  = count_after_read(rx_error_tally, re_reported, re_inc);

    // ****************************************************************
    // APB handshake: one wait state
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase  <= APB_IDLE;
            pready <= 1'b0;
        end else begin
            unique case (phase)
                APB_IDLE: begin
                    pready <= 1'b0;
                    if (psel && !penable) begin
                        phase <= APB_SETUP;
                    end
                end
                APB_SETUP: begin
                    pready <= 1'b1;
                    phase  <= APB_ACCESS;
                end
                APB_ACCESS: begin
                    pready <= 1'b0;
                    phase  <= APB_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data and error response
    // ****************************************************************
    always_comb begin
        next_read = `RESET_WORD;
        if (hit_ctrl) begin
            next_read[`CTRL_INT_EN_BIT] = int_en;
            next_read[`CTRL_INT_OE_BIT] = int_oe;
        end else if (hit_one) begin
            next_read[`ONE_FC_HALF_BIT] = false_carrier_half_pending;
            next_read[`ONE_RE_HALF_BIT] = rx_error_half_pending;
            next_read[`ONE_FC_EN_BIT]   = false_carrier_half_enable;
            next_read[`ONE_RE_EN_BIT]   = rx_error_half_enable;
        end else if (hit_two) begin
            next_read = {1'b0,
                         autoneg_fault_pending, page_received_pending,
                         loop_fifo_fault_pending, crossover_change_pending,
                         sleep_mode_pending, polarity_change_pending, jabber_pending,
                         1'b0,
                         autoneg_fault_enable, page_received_enable,
                         loop_fifo_fault_enable, crossover_change_enable,
                         sleep_mode_enable, polarity_change_enable, jabber_enable};
        end else if (hit_fc) begin
            next_read = {8'h00, false_carrier_tally};
        end else if (hit_re) begin
            next_read = rx_error_tally;
        end
    end

    // Read word is captured at the end of setup, ready with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (phase == APB_SETUP) begin
            prdata  <= {16'h0000, next_read};
            pslverr <= ~hit_any;
        end else if (phase == APB_ACCESS) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // Control and enable writes
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en     <= 1'b0;
            int_oe     <= 1'b0;
            one_enable <= 2'b00;
            two_enable <= '0;
        end else if (wr_take && pstrb[0]) begin
            if (hit_ctrl) begin
                int_en <= pwdata[`CTRL_INT_EN_BIT];
                int_oe <= pwdata[`CTRL_INT_OE_BIT];
            end
            if (hit_one) begin
                one_enable <= {pwdata[`ONE_FC_EN_BIT], pwdata[`ONE_RE_EN_BIT]};
            end
            if (hit_two) begin
                two_enable <= pwdata[6:0];
            end
        end
    end

    // ****************************************************************
    // Event status, second register
    // ****************************************************************
    // Set wins over clear; jabber bit is not cleared by read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            two_pending <= '0;
        end else if (rd_take && hit_two) begin
            two_pending <= flags_after_read(two_pending, two_reported,
                                            `TWO_COR_MASK, raw_events);
        end else begin
            two_pending <= two_pending | raw_events;
        end
    end
    // Bits 14..9 map autoneg, page, loop fifo, crossover, sleep, polarity

    // ****************************************************************
    // False carrier counter
    // ****************************************************************
    assign fc_inc        = false_carrier_event && (false_carrier_tally != `FC_MAX);
    assign fc_half_event = fc_inc && (false_carrier_tally == `FC_HALF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            false_carrier_tally <= 8'h00;
        end else if (rd_take && hit_fc) begin
            false_carrier_tally <= fc_after_read[7:0];
        end else if (fc_inc) begin
            false_carrier_tally <= false_carrier_tally + 8'h01;
        end
    end

    // ****************************************************************
    // Receive error counter
    // ****************************************************************
    assign re_inc = carrier_valid && rx_dv && invalid_symbol && !mii_loopback;
    assign re_half_event = re_inc && (rx_error_tally == `RE_HALF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_error_tally <= 16'h0000;
        end else if (rd_take && hit_re) begin
            rx_error_tally <= re_after_read;
        end else if (re_inc && rx_error_tally != `RE_MAX) begin
            rx_error_tally <= rx_error_tally + 16'h0001;
        end
    end

    // ****************************************************************
    // Half-full status in first register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            one_pending <= 2'b00;
        end else if (rd_take && hit_one) begin
            one_pending <= one_after_read[1:0];
        end else begin
            one_pending <= one_pending | {fc_half_event, re_half_event};
        end
    end

    // ****************************************************************
    // Interrupt pin
    // ****************************************************************
    assign irq_request = int_en && int_oe &&
                         (|(two_pending & two_enable) ||
                          |(one_pending & one_enable));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_powerdown_pin_out_n <= 1'b1;
            irq_powerdown_pin_oe    <= 1'b0;
            powerdown_request       <= 1'b0;
        end else begin
            irq_powerdown_pin_out_n <= ~irq_request;
            irq_powerdown_pin_oe    <= int_oe;
            powerdown_request       <= ~int_oe & ~irq_powerdown_pin_in;
        end
    end

endmodule : phy_event_status_and_error_counters

// file: test/phy_event_chk.sv
// Purpose: Port checks of the event status block
// Assumes: One APB wait state, registered pin outputs
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`include "phy_event_params.svh"
module phy_event_chk #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock, reset, APB
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Shared pin
    input wire logic                  irq_powerdown_pin_in,
    input wire logic                  irq_powerdown_pin_out_n,
    input wire logic                  irq_powerdown_pin_oe,
    input wire logic                  powerdown_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr inside {`ADDR_CONTROL, `ADDR_STATUS_ONE, `ADDR_STATUS_TWO,
                                  `ADDR_FALSE_CARRIER, `ADDR_RX_ERROR};
    a_ready_one_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("ready not two edges after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_error_unmapped: assert property (psel && !penable && !mapped |-> ##2 (pready && pslverr))
        else $error("unmapped access without error");
    a_error_mapped: assert property (psel && !penable && mapped |-> ##2 !pslverr)
        else $error("mapped access with error");
    a_irq_needs_oe: assert property (!irq_powerdown_pin_out_n |-> irq_powerdown_pin_oe)
        else $error("interrupt driven without output enable");
    a_pin_off_high: assert property (!irq_powerdown_pin_oe [*2] |-> irq_powerdown_pin_out_n)
        else $error("interrupt low while pin is input");
    a_powerdown_follow: assert property (!irq_powerdown_pin_in ##1 !irq_powerdown_pin_oe
        |-> powerdown_request)
        else $error("power-down not requested");
    a_no_powerdown_out: assert property (irq_powerdown_pin_oe [*2] |-> !powerdown_request)
        else $error("power-down while pin is output");
    c_error: cover property (pready && pslverr);
    c_irq: cover property (!irq_powerdown_pin_out_n);
    c_powerdown: cover property (powerdown_request);
endmodule : phy_event_chk

bind phy_event_status_and_error_counters phy_event_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_powerdown_pin_in(irq_powerdown_pin_in),
    .irq_powerdown_pin_out_n(irq_powerdown_pin_out_n),
    .irq_powerdown_pin_oe(irq_powerdown_pin_oe), .powerdown_request(powerdown_request));

// file: test/tb.sv
// Purpose: Self-checking bench of the event status block
// Assumes: 20 MHz pclk, APB master in the bench
// Notes:   Longest test saturates the receive error counter
`timescale 1ns/1ps
`include "phy_event_params.svh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, fc, rx_dv, cv, inv, loop_on, pin_in;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, out_n, oe, pd_req;
    logic [6:0]  ev;
    int          failures, checked;

    phy_event_status_and_error_counters dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .autoneg_fault_event(ev[6]), .page_received_event(ev[5]),
        .loop_fifo_fault_event(ev[4]), .crossover_change_event(ev[3]),
        .sleep_mode_event(ev[2]), .polarity_change_event(ev[1]), .jabber_event(ev[0]),
        .false_carrier_event(fc), .rx_dv(rx_dv), .carrier_valid(cv), .invalid_symbol(inv),
        .mii_loopback(loop_on), .irq_powerdown_pin_in(pin_in),
        .irq_powerdown_pin_out_n(out_n), .irq_powerdown_pin_oe(oe),
        .powerdown_request(pd_req));

    task chk(input string n, input logic [32:0] x, input logic [32:0] g);
        checked++;
        if (g !== x) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x,
             input string n);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (!w) chk(n, x, {pslverr, prdata});
        else chk("write pslverr", {x[32], 32'h0}, {pslverr, 32'h0});
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, "");
    endtask : wr

    task pulse(input int i);
        @(posedge pclk) ev[i] <= 1'b1;
        @(posedge pclk) ev[i] <= 1'b0;
    endtask : pulse

    task hold(input logic f, input int n);
        @(posedge pclk);
        if (f) fc <= 1'b1;
        else {rx_dv, cv, inv} <= 3'b111;
        repeat (n) @(posedge pclk);
        {fc, rx_dv, cv, inv} <= 4'h0;
    endtask : hold

    task t_status;
        apb(0, `ADDR_STATUS_TWO, 0, 33'h0, "two reset");
        apb(0, 8'h60, 0, {1'b1, 32'h0}, "unmapped");
        wr(`ADDR_STATUS_TWO, 32'h0000FFFF);
        apb(0, `ADDR_STATUS_TWO, 0, 33'h007F, "two enables");
        for (int i = 6; i >= 1; i--) begin
            pulse(i);
            apb(0, `ADDR_STATUS_TWO, 0, 33'h007F | (33'h1 << (8 + i)), "two pend");
            chk("out_n", 33'h1, {32'h0, out_n});
            apb(0, `ADDR_STATUS_TWO, 0, 33'h007F, "two cleared");
        end
        pulse(0);
        apb(0, `ADDR_STATUS_TWO, 0, 33'h017F, "jabber");
        apb(0, `ADDR_STATUS_TWO, 0, 33'h017F, "jabber kept");
        $display("test status done");
    endtask : t_status

    task t_irq;
        wr(`ADDR_CONTROL, 32'h3);
        repeat (3) @(posedge pclk);
        chk("out_n", 33'h0, {32'h0, out_n});
        wr(`ADDR_STATUS_TWO, 32'h7E);
        repeat (3) @(posedge pclk);
        chk("out_n", 33'h1, {32'h0, out_n});
        pulse(5);
        repeat (3) @(posedge pclk);
        chk("out_n", 33'h0, {32'h0, out_n});
        apb(0, `ADDR_STATUS_TWO, 0, 33'h217E, "page");
        repeat (3) @(posedge pclk);
        chk("out_n", 33'h1, {32'h0, out_n});
        wr(`ADDR_STATUS_TWO, 32'h7F);
        wr(`ADDR_CONTROL, 32'h1);
        repeat (3) @(posedge pclk);
        chk("out_n", 33'h1, {32'h0, out_n});
        wr(`ADDR_CONTROL, 32'h2);
        pin_in <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("powerdown", 33'h1, {31'h0, oe, pd_req});
        pin_in <= 1'b1;
        $display("test irq done");
    endtask : t_irq

    task t_counters;
        hold(1, 127);
        apb(0, `ADDR_STATUS_ONE, 0, 33'h0, "one below half");
        hold(1, 1);
        apb(0, `ADDR_STATUS_ONE, 0, 33'h0200, "fc half");
        apb(0, `ADDR_FALSE_CARRIER, 0, 33'h0080, "fc count");
        apb(0, `ADDR_FALSE_CARRIER, 0, 33'h0, "fc cleared");
        hold(1, 300);
        apb(0, `ADDR_FALSE_CARRIER, 0, 33'h00FF, "fc sat");
        hold(0, 5);
        apb(0, `ADDR_RX_ERROR, 0, 33'h5, "rx count");
        loop_on <= 1'b1;
        hold(0, 5);
        loop_on <= 1'b0;
        apb(0, `ADDR_RX_ERROR, 0, 33'h0, "rx loopback");
        @(posedge pclk) {rx_dv, cv, inv} <= 3'b011;
        repeat (5) @(posedge pclk);
        {rx_dv, cv, inv} <= 3'b000;
        apb(0, `ADDR_RX_ERROR, 0, 33'h0, "rx no dv");
        hold(0, 65540);
        apb(0, `ADDR_STATUS_ONE, 0, 33'h0300, "rx and fc half");
        apb(0, `ADDR_RX_ERROR, 0, 33'hFFFF, "rx sat");
        $display("test counters done");
    endtask : t_counters

    task finish_test;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        #(90000 * 50);
        failures++;
        finish_test;
    end

    initial begin
        {presetn, psel, penable, pwrite, fc, rx_dv, cv, inv, loop_on} = 9'h0;
        {paddr, pwdata, ev, pin_in} = '0;
        pin_in = 1'b1;
        failures = 0;
        checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_status;
        t_irq;
        t_counters;
        finish_test;
    end
endmodule : tb
